// [design/cdo_unit.v]
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`include "cdo_map.vh"
module cdo_unit
(
  input wire core_clk_i,
  input wire rstn_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire [2:0] irq_ack_i,
  output reg [2:0] match_flag_o,
  output reg [5:0] pin_value_o,
  output reg [5:0] pin_oe_n_o
);

  // bus address phase capture
  // only the byte offset is kept; upper address bits are ignored
  reg wr_q;
  reg [7:0] adr_q;
  wire take = hsel_i && hready_i && htrans_i[1];

  // register storage
  // compare values live twice: buf_q is what software sees, act_q what
  // the comparator uses; they differ only while a pwm update is pending,
  // which keeps a half-written period from producing an odd pulse
  reg [7:0] count_q;
  reg [7:0] buf_q [0:3];
  reg [7:0] act_q [0:3];
  reg [3:0] pend_q;
  reg [31:0] ctrl_q;
  reg [7:0] dt_q;
  reg [5:0] port_q;
  reg [5:0] ddr_q;
  reg [2:0] flag_q;
  reg blk_q;
  reg dir_q;
  reg [2:0] wave_q;
  reg [2:0] frc_q;
  reg [2:0] dtdiv_q;

  // mode decode; pfc is the dual-slope phase and frequency correct mode
  // run stands in for the clock select, so a stopped timer still blocks
  wire pwm = ctrl_q[`CDO_CTRL_PWM_A] | ctrl_q[`CDO_CTRL_PWM_B];
  wire pfc = pwm && (ctrl_q[`CDO_CTRL_WGM] == 2'b01);
  wire run = ctrl_q[`CDO_CTRL_RUN];
  wire wr_now = wr_q;
  wire [7:0] top = act_q[2];
  wire at_top = (count_q == top);
  wire at_bot = (count_q == 8'h00);

  // raw matches, blocked the cycle after a count write
  // the block flop lets software load a count equal to a compare value safely
  wire [3:0] match;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cmp
      assign match[g] = run && !blk_q && (count_q == act_q[g]);
    end
  endgenerate

  // channel index a, b, d onto compare slots 0, 1, 3
  // slot c is the top value and has no channel of its own
  function [1:0] slot;
    input integer ch;
    begin
      slot = (ch == 2) ? 2'd3 : ch[1:0];
    end
  endfunction

  // output mode field of one channel, taken live from the control word
  function [1:0] com_of;
    input integer ch;
    input [31:0] c;
    begin
      case (ch)
        0: com_of = c[`CDO_CTRL_COM_A];
        1: com_of = c[`CDO_CTRL_COM_B];
        default: com_of = c[`CDO_CTRL_COM_D];
      endcase
    end
  endfunction

  // byte address decode helper, used for writes only; the read mux decodes on its own
  // anything that is not a compare register gives 8, which no slot index
  // equals, so such a write touches no compare storage
  function [3:0] cmp_idx;
    input [7:0] a;
    begin
      case (a)
        `CDO_OFS_CMP_A: cmp_idx = 4'd0;
        `CDO_OFS_CMP_B: cmp_idx = 4'd1;
        `CDO_OFS_CMP_C: cmp_idx = 4'd2;
        `CDO_OFS_CMP_D: cmp_idx = 4'd3;
        default: cmp_idx = 4'd8;
      endcase
    end
  endfunction

  // decoded once from the held address so every compare write shares it
  wire [3:0] widx = cmp_idx(adr_q);

  // ahb-lite slave: zero wait states, always okay
  // hready is never pulled low, so the master can issue transfers back to
  // back; the price is that every readable value must already sit in a flop
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      wr_q <= take && hwrite_i;
      if (take)
        adr_q <= {haddr_i[7:2], 2'b00};
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // read mux registered off the address phase; unmapped reads zero
  // compare reads return the buffer so software sees its last write, unless the read's address phase falls in that write's data phase
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
      hrdata_o <= 32'h0000_0000;
    else if (take && !hwrite_i)
    begin
      case ({haddr_i[7:2], 2'b00})
        `CDO_OFS_COUNT: hrdata_o <= {24'h000000, count_q};
        `CDO_OFS_CMP_A: hrdata_o <= {24'h000000, buf_q[0]};
        `CDO_OFS_CMP_B: hrdata_o <= {24'h000000, buf_q[1]};
        `CDO_OFS_CMP_C: hrdata_o <= {24'h000000, buf_q[2]};
        `CDO_OFS_CMP_D: hrdata_o <= {24'h000000, buf_q[3]};
        `CDO_OFS_CTRL: hrdata_o <= {16'h0000, ctrl_q[15:0]};
        `CDO_OFS_DT: hrdata_o <= {24'h000000, dt_q};
        `CDO_OFS_FLAGS: hrdata_o <= {29'h0, flag_q};
        `CDO_OFS_PORT: hrdata_o <= {18'h0, ddr_q, 2'b00, port_q};
        `CDO_OFS_STATUS: hrdata_o <= {25'h0, wave_q, pend_q};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // control registers; force bits are strobes and never stored
  // only the low fourteen control bits are kept; force bits read back zero
  // mode bits act from the next cycle, so a new output mode meets the next match
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q <= `CDO_RST_CTRL;
      dt_q <= `CDO_RST_DT;
      port_q <= 6'h00;
      ddr_q <= 6'h00;
      frc_q <= 3'b000;
    end
    else
    begin
      frc_q <= 3'b000;
      if (wr_now && adr_q == `CDO_OFS_CTRL)
      begin
        ctrl_q <= {16'h0000, 2'b00, hwdata_i[13:0]};
        frc_q <= hwdata_i[18:16];
      end
      if (wr_now && adr_q == `CDO_OFS_DT)
        dt_q <= hwdata_i[7:0];
      if (wr_now && adr_q == `CDO_OFS_PORT)
      begin
        port_q <= hwdata_i[5:0];
        ddr_q <= hwdata_i[13:8];
      end
    end
  end

  // counter: cpu write wins; normal/fast up to top, pfc up-down
  // pfc turns round at both end points, so top and bottom last one cycle
  // each and the period is symmetric around the top value
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      count_q <= 8'h00;
      blk_q <= 1'b0;
      dir_q <= 1'b0;
    end
    else
    begin
      blk_q <= wr_now && adr_q == `CDO_OFS_COUNT;
      if (wr_now && adr_q == `CDO_OFS_COUNT)
        count_q <= hwdata_i[7:0];
      else if (run)
      begin
        if (pfc)
        begin
          if (at_top && !dir_q)
            dir_q <= 1'b1;
          else if (at_bot && dir_q)
            dir_q <= 1'b0;
          if ((at_top && !dir_q) || (dir_q && !at_bot))
            count_q <= count_q - 8'h01;
          else
            count_q <= count_q + 8'h01;
        end
        else if (at_top)
          count_q <= 8'h00;
        else
          count_q <= count_q + 8'h01;
      end
    end
  end

  // update point for buffered compare values
  // fast pwm updates at top, dual slope at bottom while counting down
  wire upd = run && (pfc ? (at_bot && dir_q) : at_top);

  // compare storage: direct in normal mode, buffered under pwm
  // a write that meets the update point in the same cycle wins; the new
  // value then waits for the next update instead of being lost
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_buf
      always @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          buf_q[g] <= `CDO_RST_CMP;
          act_q[g] <= `CDO_RST_CMP;
          pend_q[g] <= 1'b0;
        end
        else if (wr_now && widx == g)
        begin
          buf_q[g] <= hwdata_i[7:0];
          if (!pwm)
            act_q[g] <= hwdata_i[7:0];
          pend_q[g] <= pwm;
        end
        else if (pend_q[g] && (upd || !pwm))
        begin
          act_q[g] <= buf_q[g];
          pend_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // flags, waveform and dead time for channels a, b, d
  // the divider runs freely, so the first tick after an edge may come early
  // by up to one prescaled period; dead times are exact only to that step,
  // traded for a single divider shared by all three stages
  wire [3:0] dtps = 4'd1 << ctrl_q[`CDO_CTRL_DTPS];
  wire [2:0] dtdiv_max = dtps[2:0] - 3'd1;
  wire dt_tick = (dtdiv_q == dtdiv_max) || (dtps == 4'd1);

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
      dtdiv_q <= 3'd0;
    else if (dt_tick)
      dtdiv_q <= 3'd0;
    else
      dtdiv_q <= dtdiv_q + 3'd1;
  end

  // one stage per channel: waveform state, flag, dead time counter, pin mux
  // channel d reads compare slot 3, skipping the top register
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ch
      reg [3:0] dtc_q;
      reg wprev_q;
      reg hi_q;
      reg lo_q;
      wire [1:0] com = com_of(g, ctrl_q);
      wire m = match[slot(g)];
      wire fire = m || (frc_q[g] && !pwm);
      wire comp = pwm && (com == 2'b01);
      wire on = wave_q[g];
      wire inv = ctrl_q[`CDO_CTRL_INV];
      reg nxt;
      // waveform action per mode; state kept on mode change
      // a force under pwm is dropped, as the pair would lose its dead time
      always @*
      begin
        nxt = on;
        if (fire && com != 2'b00)
        begin
          if (!pwm)
            nxt = (com == 2'b01) ? !on : (com == 2'b11);
          else if (com == 2'b11)
            nxt = 1'b1;
          else
            nxt = 1'b0;
        end
        else if (pwm && com != 2'b00 && !fire)
        begin
          if (pfc ? (at_bot && dir_q) : (at_top && run))
            nxt = (com != 2'b11);
        end
      end
      always @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          wave_q[g] <= 1'b0;
          flag_q[g] <= 1'b0;
          dtc_q <= 4'h0;
          wprev_q <= 1'b0;
          hi_q <= 1'b0;
          lo_q <= 1'b0;
          pin_value_o[2*g+1 -: 2] <= 2'b00;
          pin_oe_n_o[2*g+1 -: 2] <= 2'b11;
          match_flag_o[g] <= 1'b0;
        end
        else
        begin
          wave_q[g] <= nxt;
          // set wins over clear
          // match_flag_o mirrors the next flag value so port and flop agree
          if (m)
            flag_q[g] <= 1'b1;
          else if (irq_ack_i[g] || (wr_now && adr_q == `CDO_OFS_FLAGS && hwdata_i[g]))
            flag_q[g] <= 1'b0;
          match_flag_o[g] <= m || (flag_q[g] && !(irq_ack_i[g] ||
            (wr_now && adr_q == `CDO_OFS_FLAGS && hwdata_i[g])));
          wprev_q <= on;
          // dead time: edge loads counter, rising side waits for zero
          // both sides drop at once on an edge, so hi_q and lo_q can never be high together
          if (on != wprev_q)
          begin
            dtc_q <= on ? dt_q[`CDO_DT_RISE] : dt_q[`CDO_DT_FALL];
            hi_q <= 1'b0;
            lo_q <= 1'b0;
          end
          else if (dtc_q != 4'h0)
          begin
            if (dt_tick)
              dtc_q <= dtc_q - 4'h1;
          end
          else
          begin
            hi_q <= on;
            lo_q <= !on;
          end
          // pin mux; direction register keeps control of the enable
          // the second pin shows port data outside complementary mode, and
          // the enable never follows the mode, so software sets direction first
          if (comp)
            pin_value_o[2*g+1 -: 2] <= {lo_q ^ inv, hi_q ^ inv};
          else if (com != 2'b00)
            pin_value_o[2*g+1 -: 2] <= {port_q[2*g+1], wprev_q};
          else
            pin_value_o[2*g+1 -: 2] <= port_q[2*g+1 -: 2];
          pin_oe_n_o[2*g+1 -: 2] <= ~ddr_q[2*g+1 -: 2];
        end
      end
    end
  endgenerate

endmodule // cdo_unit

// [design/cdo_map.vh]
`ifndef CDO_MAP_VH
`define CDO_MAP_VH
`define CDO_OFS_COUNT 8'h00
`define CDO_OFS_CMP_A 8'h04
`define CDO_OFS_CMP_B 8'h08
`define CDO_OFS_CMP_C 8'h0c
`define CDO_OFS_CMP_D 8'h10
`define CDO_OFS_CTRL 8'h14
`define CDO_OFS_DT 8'h18
`define CDO_OFS_FLAGS 8'h1c
`define CDO_OFS_PORT 8'h20
`define CDO_OFS_STATUS 8'h24
`define CDO_CTRL_COM_A 1:0
`define CDO_CTRL_COM_B 3:2
`define CDO_CTRL_COM_D 5:4
`define CDO_CTRL_PWM_A 6
`define CDO_CTRL_PWM_B 7
`define CDO_CTRL_WGM 9:8
`define CDO_CTRL_DTPS 11:10
`define CDO_CTRL_INV 12
`define CDO_CTRL_RUN 13
`define CDO_CTRL_FOC_A 16
`define CDO_CTRL_FOC_B 17
`define CDO_CTRL_FOC_D 18
`define CDO_DT_RISE 7:4
`define CDO_DT_FALL 3:0
`define CDO_RST_CMP 8'hff
`define CDO_RST_DT 8'h00
`define CDO_RST_CTRL 32'h0000_0000
`endif

// [verification/cdo_unit_asserts.sv]
`timescale 1ns/1ns
module cdo_unit_asserts
(
  input wire core_clk_i,
  input wire rstn_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire [2:0] irq_ack_i,
  input wire [2:0] match_flag_o,
  input wire [5:0] pin_value_o,
  input wire [5:0] pin_oe_n_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire take = hsel_i & hready_i & htrans_i[1];
  reg wr_q;
  reg [7:0] adr_q;
  reg [2:0] keep_q;
  reg [5:0] oen_q;
  // write data phase shadow; a flag may only drop on ack or a written one
  always @(posedge core_clk_i)
  begin
    wr_q <= take & hwrite_i;
    adr_q <= haddr_i[7:0];
    keep_q <= match_flag_o & ~irq_ack_i & ~((wr_q && adr_q == 8'h1c) ? hwdata_i[2:0] : 3'h0);
    if (wr_q && adr_q == 8'h20)
      oen_q <= ~hwdata_i[13:8];
  end
  a_resp_okay:
    assert property (hresp_o == 1'b0) else $error("error response");
  a_no_wait:
    assert property (hreadyout_o == 1'b1) else $error("wait state");
  a_reset_outputs:
    assert property ($past(rstn_i) == 1'b0 |-> pin_value_o == 6'h00
      && pin_oe_n_o == 6'h3f && match_flag_o == 3'h0) else $error("outputs not reset");
  a_rdata_hold:
    assert property (!(take && !hwrite_i) |=> $stable(hrdata_o)) else $error("read data moved");
  a_unmapped_zero:
    assert property (take && !hwrite_i && haddr_i[7:0] > 8'h27 |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
  a_dir_to_oe:
    assert property (wr_q && adr_q == 8'h20 |=> ##[0:1] pin_oe_n_o == oen_q)
      else $error("enable not from direction");
  a_flag_sticky:
    assert property ((keep_q & ~match_flag_o) == 3'h0) else $error("flag dropped");
  a_count_block:
    assert property (wr_q && adr_q == 8'h00 |-> ##2 (match_flag_o & ~$past(match_flag_o)) == 3'h0)
      else $error("match after count write");
endmodule // cdo_unit_asserts
bind cdo_unit cdo_unit_asserts u_asserts (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .irq_ack_i(irq_ack_i), .match_flag_o(match_flag_o),
  .pin_value_o(pin_value_o), .pin_oe_n_o(pin_oe_n_o));

// [verification/cdo_switch_model.sv]
`timescale 1ns/1ns
module cdo_switch_model
(
  input wire core_clk_i,
  input wire [5:0] pin_value_i,
  input wire [5:0] pin_oe_n_i,
  output integer overlap_o,
  output integer edges_o
);
  logic last_q;
  initial
  begin
    overlap_o = 0;
    edges_o = 0;
    last_q = 1'b0;
  end
  // leg a: both switches on at once shorts the supply, so count it
  always @(posedge core_clk_i)
  begin
    last_q <= pin_value_i[0];
    if (pin_oe_n_i[1:0] == 2'b00 && pin_value_i[1:0] == 2'b11)
      overlap_o <= overlap_o + 1;
    if (pin_value_i[0] && !last_q)
      edges_o <= edges_o + 1;
  end
endmodule // cdo_switch_model

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] ack = 3'h0;
  wire [31:0] hrdata;
  wire hrdy;
  wire [2:0] flag;
  wire [5:0] pin;
  wire [5:0] oen;
  integer miscompares = 0;
  integer n_tests = 0;
  integer ovl;
  integer edg;
  integer o0;
  integer e0;
  logic [31:0] q;
  always #5 clk = ~clk;
  cdo_unit i_dut (.core_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(),
    .irq_ack_i(ack), .match_flag_o(flag), .pin_value_o(pin), .pin_oe_n_o(oen));
  cdo_switch_model i_sw (.core_clk_i(clk), .pin_value_i(pin), .pin_oe_n_i(oen),
    .overlap_o(ovl), .edges_o(edg));
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        miscompares++;
        $display("BAD %s exp %h got %h", s, e, g);
      end
    end
  endtask
  // one single transfer; always starts right after an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      q = hrdata;
    end
  endtask
  task rd(input string s, input logic [7:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      cmp(s, e, q);
    end
  endtask
  task results;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    cmp("pin", 32'h0, {26'h0, pin});
    cmp("oe", 32'h3f, {26'h0, oen});
    cmp("flag", 32'h0, {29'h0, flag});
    rd("ctrl", 8'h14, 32'h0);
    rd("cmp_a", 8'h04, 32'hff);
    rd("unmapped", 8'h40, 32'h0);
    bus(1'b1, 8'h20, 32'h3f00);
    bus(1'b1, 8'h14, 32'h10000);
    tick(3);
    cmp("pin_a", 32'h0, {31'h0, pin[0]});
    rd("wave_a", 8'h24, 32'h0);
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b1, 8'h14, 32'h10001);
    tick(3);
    cmp("pin_a", 32'h1, {31'h0, pin[0]});
    cmp("flag", 32'h0, {29'h0, flag});
    bus(1'b1, 8'h14, 32'h2000c);
    tick(1);
    rd("wave_b", 8'h24, 32'h30);
    bus(1'b1, 8'h04, 32'h3);
    rd("cmp_a", 8'h04, 32'h3);
    bus(1'b1, 8'h0c, 32'hf);
    bus(1'b1, 8'h14, 32'h2001);
    repeat (40) if (flag[0] !== 1'b1) tick(1);
    cmp("flag", 32'h1, {29'h0, flag});
    @(posedge clk);
    ack <= 3'h1;
    @(posedge clk);
    ack <= 3'h0;
    tick(1);
    cmp("ack", 32'h0, {29'h0, flag});
    repeat (40) if (flag[0] !== 1'b1) tick(1);
    bus(1'b1, 8'h1c, 32'h1);
    tick(1);
    cmp("w1c", 32'h0, {29'h0, flag});
    bus(1'b1, 8'h00, 32'h3);
    tick(3);
    cmp("block", 32'h0, {29'h0, flag});
    bus(1'b1, 8'h00, 32'h1);
    rd("count", 8'h00, 32'h2);
    repeat (40) if (flag[0] !== 1'b1) tick(1);
    cmp("match", 32'h1, {29'h0, flag});
    bus(1'b1, 8'h18, 32'h22);
    bus(1'b1, 8'h04, 32'h8);
    o0 = ovl;
    e0 = edg;
    bus(1'b1, 8'h14, 32'h2441);
    bus(1'b1, 8'h04, 32'h5);
    rd("buf", 8'h04, 32'h5);
    tick(100);
    cmp("ovl", o0, ovl);
    cmp("edges", 32'h1, {31'h0, (edg - e0) > 4});
    bus(1'b1, 8'h14, 32'h3441);
    tick(100);
    cmp("inv", 32'h1, {31'h0, ovl > o0});
    results;
  end
  // cut a hang short
  initial
  begin
    tick(5000);
    miscompares++;
    results;
  end
endmodule // tb
